// ==== logic/channel_dcblock_phase_cal.sv ====
// Per-channel decimation with phase-shifted windows and DC-blocking filter.
// Assumes i_clk is the modulator clock and an APB master drives the bus.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps

module channel_dcblock_phase_cal (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Modulator bit streams
  input wire logic [dcblock_pkg::NCH-1:0] i_mod_bits,
  // Conversion ready, active low
  output logic o_conversion_ready_n
);

  localparam int NCH = dcblock_pkg::NCH;
  localparam int SW = dcblock_pkg::SMP_W;

  typedef struct packed {
    logic [NCH-1:0] mod_meta;
    logic [NCH-1:0] mod_sync;
    logic [3:0] cutoff;
    logic [2:0] osr_sel;
    logic [NCH-1:0][dcblock_pkg::CHCFG_W-1:0] chcfg;
    logic [dcblock_pkg::CNT_W-1:0] gcnt;
    logic [4:0] tcnt;
    logic [NCH-1:0][dcblock_pkg::ACC_W-1:0] acc;
    logic [NCH-1:0][SW-1:0] xprev;
    logic [NCH-1:0][SW-1:0] hp;
    logic [NCH-1:0][SW-1:0] sample;
    logic [NCH-1:0] fresh;
    logic ready_n;
    logic rd_ok;
    logic [31:0] prdata;
  } state_t;

  localparam state_t ST_RST = '{
    cutoff: dcblock_pkg::CUTOFF_RST,
    osr_sel: dcblock_pkg::OSR_RST,
    ready_n: 1'b1,
    default: '0
  };

  // ==========================================================
  // Helpers

  // OSR minus one, used as the window counter mask
  function automatic logic [13:0] osr_mask(input logic [2:0] sel);
    logic [31:0] osr;
    osr = dcblock_pkg::OSR_BASE << sel;
    return 14'(osr - 32'h1);
  endfunction

  // Saturate the programmed phase to the OSR-dependent range
  function automatic logic [9:0] phase_clip(input logic [9:0] ph, input logic [2:0] sel);
    int p;
    int lim;
    p = int'($signed(ph));
    if (sel >= dcblock_pkg::OSR_SEL_CAP) begin
      lim = dcblock_pkg::PHASE_CAP;
    end else begin
      lim = int'(dcblock_pkg::OSR_BASE >> 1) << sel;
    end
    if (p > lim - 1) begin
      p = lim - 1;
    end
    if (p < -lim) begin
      p = -lim;
    end
    return 10'(p);
  endfunction

  state_t st;
  state_t nx;
  logic [13:0] mask;
  logic [NCH-1:0] bitv;
  logic [NCH-1:0] wend;
  logic [NCH-1:0][9:0] clipped;
  logic [NCH-1:0][SW-1:0] xv;
  logic [NCH-1:0] set_fresh;
  logic [NCH-1:0] clr_fresh;
  logic [31:0] rdv;
  logic hit;
  logic any_wend;
  logic [SW-1:0] coef_ref;

  assign o_pready = i_psel & i_penable & st.rd_ok & i_ce;
  assign o_pslverr = o_pready & ~hit;
  assign o_prdata = st.prdata;
  assign o_conversion_ready_n = st.ready_n;

  // ==========================================================
  // Next state
  always_comb begin
    logic [15:0] s;
    logic [SW-1:0] y;
    logic [4:0] k;
    logic test_hi;
    logic [7:0] a_cfg;
    logic [7:0] a_smp;
    s = '0;
    y = '0;
    a_cfg = '0;
    a_smp = '0;
    k = {1'b0, st.cutoff} + 5'h01;
    nx = st;
    mask = osr_mask(st.osr_sel);
    nx.mod_meta = i_mod_bits;
    nx.mod_sync = st.mod_meta;
    nx.gcnt = (st.gcnt + 14'h0001) & mask;
    nx.tcnt = (st.tcnt == dcblock_pkg::TEST_LAST) ? 5'h00 : st.tcnt + 5'h01;
    test_hi = st.tcnt < dcblock_pkg::TEST_ONES;
    set_fresh = '0;
    clr_fresh = '0;
    rdv = '0;
    hit = 1'b0;
    case (i_paddr)
      dcblock_pkg::ADDR_CTRL: begin
        hit = 1'b1;
        rdv = {25'h0, st.osr_sel, st.cutoff};
      end
      dcblock_pkg::ADDR_STATUS: begin
        hit = 1'b1;
        rdv = {26'h0, st.fresh};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    for (int c = 0; c < NCH; c++) begin
      clipped[c] = phase_clip(st.chcfg[c][dcblock_pkg::PHASE_LSB +: 10], st.osr_sel);
      case (dcblock_pkg::insel_t'(st.chcfg[c][dcblock_pkg::INSEL_LSB +: 2]))
        dcblock_pkg::IN_EXT: bitv[c] = st.mod_sync[c];
        dcblock_pkg::IN_SHORT: bitv[c] = st.tcnt[0];
        dcblock_pkg::IN_TEST_POS: bitv[c] = test_hi;
        dcblock_pkg::IN_TEST_NEG: bitv[c] = ~test_hi;
        default: bitv[c] = st.mod_sync[c];
      endcase
      s = st.acc[c] + (bitv[c] ? 16'h0001 : 16'hFFFF);
      xv[c] = {{8{s[15]}}, s};
      // Window ends where (count - phase) wraps; zero phase aligns all
      wend[c] = ((st.gcnt - {{4{clipped[c][9]}}, clipped[c]}) & mask) == mask;
      if (wend[c]) begin
        nx.acc[c] = '0;
        y = xv[c] - st.xprev[c] + st.hp[c] - SW'($signed(st.hp[c]) >>> k);
        nx.xprev[c] = xv[c];
        set_fresh[c] = 1'b1;
        if (st.cutoff == 4'h0 || st.chcfg[c][dcblock_pkg::HPDIS_BIT]) begin
          nx.sample[c] = xv[c];
          nx.hp[c] = '0;
        end else begin
          nx.sample[c] = y;
          nx.hp[c] = y;
        end
      end else begin
        nx.acc[c] = s;
      end
      a_cfg = dcblock_pkg::ADDR_CHCFG0 + 8'(c * 4);
      a_smp = dcblock_pkg::ADDR_SAMPLE0 + 8'(c * 4);
      if (i_paddr == a_cfg) begin
        hit = 1'b1;
        rdv = {19'h0, st.chcfg[c]};
      end
      if (i_paddr == a_smp) begin
        hit = 1'b1;
        rdv = {8'h00, st.sample[c]};
      end
      if (o_pready && i_pwrite && i_paddr == a_cfg) begin
        nx.chcfg[c] = i_pwdata[dcblock_pkg::CHCFG_W-1:0];
      end
    end
    // APB: data latched once per transfer, answered the next cycle
    if (i_psel && !st.rd_ok) begin
      nx.prdata = rdv;
    end
    nx.rd_ok = i_psel & ~o_pready;
    if (o_pready && i_pwrite && i_paddr == dcblock_pkg::ADDR_CTRL) begin
      nx.cutoff = i_pwdata[dcblock_pkg::CUTOFF_LSB +: 4];
      nx.osr_sel = i_pwdata[dcblock_pkg::OSR_LSB +: 3];
    end
    // Only flags that the read returned are cleared, later ones survive
    if (o_pready && !i_pwrite && i_paddr == dcblock_pkg::ADDR_STATUS) begin
      clr_fresh = st.prdata[NCH-1:0];
    end
    // A new sample in the clearing cycle stays flagged
    nx.fresh = (st.fresh & ~clr_fresh) | set_fresh;
    // Ready falls when the last phase-shifted window completes
    nx.ready_n = ~&nx.fresh;
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= ST_RST;
    end else if (i_ce) begin
      st <= nx;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Helpers for sampled checks
  assign any_wend = |wend;
  assign coef_ref = xv[1] - st.xprev[1] + st.hp[1] - SW'($signed(st.hp[1]) >>> 2);

  a_global_bypass: assert property (
    (i_ce && wend[0] && st.cutoff == 4'h0) |=> st.sample[0] == $past(xv[0]))
    else $error("Sample not bypassed with cutoff zero");

  a_chan_bypass: assert property (
    (i_ce && wend[0] && st.chcfg[0][12]) |=> st.sample[0] == $past(xv[0]))
    else $error("Channel disable did not bypass filter");

  a_coef_quarter: assert property (
    (i_ce && wend[1] && st.cutoff == 4'h1 && !st.chcfg[1][12]) |=>
      st.sample[1] == $past(coef_ref))
    else $error("Code one did not use coefficient one quarter");

  a_hp_state: assert property (
    (i_ce && !wend[0]) |=> $stable(st.hp[0]) && $stable(st.xprev[0]))
    else $error("Filter state moved between output samples");

  a_test_level: assert property (
    (st.chcfg[3][11:10] == 2'b10 && st.tcnt < 5'h11) |-> bitv[3])
    else $error("Positive test level not applied");

  a_phase_sign: assert property (
    (st.osr_sel == 3'h0 && st.chcfg[1][9:0] == 10'h2D4) |-> clipped[1] == 10'h3C0)
    else $error("Phase not read as signed");

  a_window_align: assert property (
    (clipped[0] == 10'h000 && clipped[1] == 10'h000) |-> wend[0] == wend[1])
    else $error("Zero-phase windows not aligned");

  a_window_shift: assert property (
    (st.osr_sel == 3'h0 && clipped[1] == 10'h005 && st.gcnt == 14'h0004) |-> wend[1])
    else $error("Window not shifted by phase count");

  a_phase_clip: assert property (
    (st.osr_sel == 3'h0 && st.chcfg[1][9:0] == 10'h064) |-> clipped[1] == 10'h03F)
    else $error("Phase 100 at OSR 128 not clipped to 63");

  a_phase_cap: assert property (
    (st.osr_sel == 3'h3) |-> clipped[1] == st.chcfg[1][9:0])
    else $error("Phase clipped at the capped range");

  a_phase_half: assert property (
    (st.osr_sel == 3'h1) |-> ($signed(clipped[1]) >= -128 && $signed(clipped[1]) <= 127))
    else $error("Phase outside half OSR range");

  a_fresh_set: assert property (
    (i_ce && wend[1]) |=> st.fresh[1])
    else $error("Window end did not flag a new sample");

  a_ext_path: assert property (
    (st.chcfg[5][11:10] == 2'b00) |-> bitv[5] == st.mod_sync[5])
    else $error("External input not routed");

  a_hp_cleared: assert property (
    (i_ce && wend[0] && st.chcfg[0][12]) |=> st.hp[0] == '0)
    else $error("Bypassed channel kept filter state");

  a_chan_filtered: assert property (
    (i_ce && wend[1] && st.cutoff != 4'h0 && !st.chcfg[1][12]) |=> st.hp[1] == st.sample[1])
    else $error("Filtered channel state not carried");

  a_ready_fall: assert property (
    $fell(o_conversion_ready_n) |-> $past(i_ce) && $past(any_wend))
    else $error("Ready fell without a window end");

  c_filtered: cover property (i_ce && wend[0] && st.cutoff != 4'h0);
  c_ready: cover property ($fell(o_conversion_ready_n));
  c_clipped: cover property (clipped[1] != st.chcfg[1][9:0]);
  c_test_level: cover property (st.chcfg[3][11:10] == 2'b10 && bitv[3]);
  c_phase_neg: cover property ($signed(clipped[1]) < 0);

endmodule

// ==== logic/dcblock_pkg.sv ====
// Constants shared by the channel high-pass and phase calibration block.
// Assumes a 32-bit APB master and one modulator bit per channel per clock.
package dcblock_pkg;

  // ==========================================================
  // Sizes
  localparam int NCH = 6;
  localparam int PH_W = 10;
  localparam int CNT_W = 14;
  localparam int ACC_W = 16;
  localparam int SMP_W = 24;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CHCFG0 = 8'h08;
  localparam logic [7:0] ADDR_SAMPLE0 = 8'h20;
  localparam logic [7:0] ADDR_STEP = 8'h04;

  // ==========================================================
  // Field positions
  localparam int CUTOFF_LSB = 0;
  localparam int OSR_LSB = 4;
  localparam int PHASE_LSB = 0;
  localparam int INSEL_LSB = 10;
  localparam int HPDIS_BIT = 12;
  localparam int CHCFG_W = 13;

  // ==========================================================
  // Reset values
  localparam logic [3:0] CUTOFF_RST = 4'h0;
  localparam logic [2:0] OSR_RST = 3'h3;
  localparam logic [CHCFG_W-1:0] CHCFG_RST = 13'h0000;

  // ==========================================================
  // Timing and limits
  localparam logic [31:0] OSR_BASE = 32'h0000_0080;
  localparam int PHASE_CAP = 512;
  localparam logic [2:0] OSR_SEL_CAP = 3'h3;
  localparam logic [4:0] TEST_LAST = 5'h1D;
  localparam logic [4:0] TEST_ONES = 5'h11;

  // ==========================================================
  // Input selection
  typedef enum logic [1:0] {
    IN_EXT = 2'b00,
    IN_SHORT = 2'b01,
    IN_TEST_POS = 2'b10,
    IN_TEST_NEG = 2'b11
  } insel_t;

endpackage

// ==== test/mod_source.sv ====
// Modulator stand-in: constant bit streams per channel.
// Assumes the bench changes i_split after a rising edge.
`timescale 1ns/100ps
// ==========================================
// Source
module mod_source (
  // Mode
  input wire logic i_split,
  // Bit streams
  output logic [5:0] o_bits
);
  // Split: even channels all ones, odd channels all zeros
  assign o_bits = i_split ? 6'h15 : 6'h3F;
endmodule

// ==== test/tb_channel_dcblock_phase_cal.sv ====
// Bench for the channel high-pass and phase block.
// Assumes an APB master at 40 MHz and constant modulator streams.
`timescale 1ns/100ps
module tb_channel_dcblock_phase_cal;
  localparam logic [7:0] ctl_a = dcblock_pkg::ADDR_CTRL;
  localparam logic [7:0] st_a = dcblock_pkg::ADDR_STATUS;
  localparam logic [7:0] cfg_a = dcblock_pkg::ADDR_CHCFG0;
  localparam logic [7:0] smp_a = dcblock_pkg::ADDR_SAMPLE0;
  logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, er, split;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic o_pready, o_pslverr, o_conversion_ready_n;
  logic [5:0] bits;
  logic [23:0] s[6];
  logic signed [23:0] y;
  int err_count, compares, cyc;

  mod_source u_mod_source (.i_split(split), .o_bits(bits));
  channel_dcblock_phase_cal u_channel_dcblock_phase_cal (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_ce(1'b1), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_mod_bits(bits), .o_conversion_ready_n(o_conversion_ready_n));

  // ==========================================
  // Clock and helpers
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) cyc <= cyc + 1;

  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task tally_and_finish;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // Wait for a full set, clear flags, read all samples
  task grab;
    while (o_conversion_ready_n !== 1'b0) @(posedge i_clk);
    apb(1'b0, st_a, 32'h0);
    chk("status", {26'h0, rd[5:0]}, 32'h3F);
    for (int c = 0; c < 6; c++) begin
      apb(1'b0, smp_a + 8'(4 * c), 32'h0);
      s[c] = rd[23:0];
    end
    chk("ready_n", {31'h0, o_conversion_ready_n}, 32'h1);
  endtask

  function automatic int expd(input int code, input int p);
    int osr, hi;
    osr = 128 << code;
    hi = (osr / 2 > 512) ? 511 : osr / 2 - 1;
    p = (p > hi) ? hi : (p < -hi - 1) ? -hi - 1 : p;
    return (p + osr) % osr;
  endfunction

  // Distance from channel 0 window end to channel 1 window end
  task meas(input int code, input int p);
    int t0, d, osr;
    osr = 128 << code;
    apb(1'b1, ctl_a, 32'(code << 4));
    apb(1'b1, cfg_a + 8'h04, {22'h0, 10'(p)});
    // Drop flags left from the previous setting
    apb(1'b0, st_a, 32'h0);
    rd = 32'h0;
    while (rd[0] !== 1'b1) apb(1'b0, st_a, 32'h0);
    t0 = cyc;
    rd = 32'h0;
    while (rd[1] !== 1'b1) apb(1'b0, st_a, 32'h0);
    d = (cyc - t0 - expd(code, p) + 2 * osr) % osr;
    chk("phase", 32'(d <= 3 || d >= osr - 3), 32'h1);
  endtask

  // ==========================================
  // Tests
  initial begin
    i_rst_n = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    split = 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    apb(1'b0, ctl_a, 32'h0);
    chk("ctrl", rd, 32'h30);
    apb(1'b0, cfg_a, 32'h0);
    chk("chcfg", rd, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    meas(0, 0);
    meas(0, 5);
    meas(0, 100);
    meas(0, -300);
    meas(1, 200);
    meas(1, -100);
    meas(3, -512);
    apb(1'b1, cfg_a + 8'h04, 32'h0);
    split <= 1'b1;
    apb(1'b1, ctl_a, 32'h0);
    apb(1'b1, cfg_a + 8'h08, 32'h400);
    apb(1'b1, cfg_a + 8'h0C, 32'h800);
    apb(1'b1, cfg_a + 8'h10, 32'hC00);
    grab;
    grab;
    chk("ones", {8'h0, s[0]}, 32'h80);
    chk("zeros", {8'h0, s[5]}, 32'hFFFF80);
    chk("short", {8'h0, s[2]}, 32'h0);
    chk("pos", 32'($signed(s[3]) > 0), 32'h1);
    chk("neg", 32'($signed(s[4]) < 0), 32'h1);
    apb(1'b1, cfg_a, 32'h1000);
    for (int k = 1; k < 4; k += 2) begin
      split <= ~split;
      apb(1'b1, ctl_a, 32'(k));
      grab;
      grab;
      y = s[1];
      grab;
      chk("decay", {8'h0, s[1]}, {8'h0, y - (y >>> (k + 1))});
      chk("bypass", {8'h0, s[0]}, 32'h80);
    end
    tally_and_finish;
  end

  initial begin
    #(25 * 60000);
    err_count++;
    tally_and_finish;
  end
endmodule
